// >>> hw/cped_pkg.sv
// constants shared by the complementary pwm event block
package cped_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_RSEL = 8'h08;
   localparam logic [7:0] OFF_FSEL = 8'h0C;
   localparam logic [7:0] OFF_REDGE = 8'h10;
   localparam logic [7:0] OFF_FEDGE = 8'h14;
   localparam logic [7:0] OFF_RDB = 8'h18;
   localparam logic [7:0] OFF_FDB = 8'h1C;
   localparam logic [7:0] OFF_RBK = 8'h20;
   localparam logic [7:0] OFF_FBK = 8'h24;
   localparam logic [7:0] OFF_RPH = 8'h28;
   localparam logic [7:0] OFF_FPH = 8'h2C;
   localparam logic [7:0] OFF_STAT = 8'h30;
   // control a fields
   localparam int CA_EN = 0;
   localparam int CA_SDE = 1;
   localparam int CA_POE = 2;
   localparam int CA_SOE = 3;
   localparam int CA_PPOL = 4;
   localparam int CA_SPOL = 5;
   // control b fields
   localparam int CB_RDBM = 0;
   localparam int CB_FDBM = 1;
   localparam int CB_CSEL = 2;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam int CNT_W = 8;
   // timer slots
   localparam int T_RPH = 0;
   localparam int T_FPH = 1;
   localparam int T_RDB = 2;
   localparam int T_FDB = 3;
   localparam int T_RBK = 4;
   localparam int T_FBK = 5;
   localparam int N_TMR = 6;
   // delay element and clock period
   localparam int ELEM_NS = 5;
   localparam int CLK_NS = 10;
   // timing clock dividers
   localparam logic [7:0] TICK_DIV_B = 8'h04;
   localparam logic [7:0] TICK_DIV_C = 8'h08;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      OVR_LOW = 2'b00,
      OVR_HIGH = 2'b01,
      OVR_TRI = 2'b10,
      OVR_INACT = 2'b11
   } cped_ovr_e;
endpackage

// >>> hw/cped_tmr_if.sv
// control and status of one interval timer
`timescale 1ns/10ps
interface cped_tmr_if;
   logic start;
   logic stop;
   logic tick;
   logic [cped_pkg::CNT_W-1:0] count;
   logic busy;
   logic done;
   modport ctl (output start, stop, tick, count, input busy, done);
   modport tmr (input start, stop, tick, count, output busy, done);
endinterface

// >>> hw/cped_timer.sv
// interval timer counting ticks from zero up to a count
`timescale 1ns/10ps
module cped_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   cped_tmr_if.tmr t
);
   typedef struct packed {
      logic busy;
      logic [cped_pkg::CNT_W-1:0] cnt;
   } cped_tmr_s;
   cped_tmr_s s_reg;
   cped_tmr_s s_next;
   logic done_c;

   always_comb begin
      s_next = s_reg;
      done_c = 1'b0;
      if (t.start) begin
         s_next.busy = (t.count != '0);
         s_next.cnt = '0;
      end else if (t.stop) begin
         s_next.busy = 1'b0;
      end else if (s_reg.busy && t.tick) begin
         if (s_reg.cnt + 1'b1 >= t.count) begin
            s_next.busy = 1'b0;
            done_c = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign t.busy = s_reg.busy;
   assign t.done = done_c;
endmodule

// >>> hw/cped_top.sv
// event driven complementary pwm stage with dead band and blanking
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - rising event is OR of selected rising sources; falling likewise
// - per-source bit picks edge (1) or level (0) detection
// - rising event: phase delay, clear secondary, blank, dead band, set primary
// - zero rising phase and dead band: primary active at once
// - falling event: phase delay, clear primary, blank, dead band, set secondary
// - zero falling phase and dead band: secondary active at once
// - disabled or just enabled: primary inactive, secondary active
// - cleared pin enable: pin not driven
// - set pin enable: override or pwm level reaches the pin
// - pin enables independent of module enable; idle levels with polarity
// - shutdown while disabled shows override levels
// - shutdown cleared only by enabled rising event or reset
// - polarity bit set makes that output active low
// - forced override levels ignore polarity
// - two dead-band timers, each chain or counter mode
// - chain mode: count of 5 ns elements, zero disables
// - counter mode: timing-clock periods from zero to count
// - rising dead band starts at rising event, before primary on
// - falling dead band starts at falling event, before secondary on
// - falling during rising dead band: suppress primary, extend, secondary on
// - rising during falling dead band: suppress secondary, extend, primary on
// - cross-coupled blanking runs full count of timing-clock periods
// - zero blanking count lets events straight through
// - zero phase count passes the event straight on
module cped_top #(
   parameter int SRC_W = 4,
   parameter int ADDR_W = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [SRC_W-1:0] rise_src_i,
   input wire logic [SRC_W-1:0] fall_src_i,
   input wire logic shutdown_i,
   input wire logic [1:0] primary_override_i,
   input wire logic [1:0] secondary_override_i,
   output logic primary_output_o,
   output logic primary_output_oe_n_o,
   output logic secondary_output_o,
   output logic secondary_output_oe_n_o
);
   localparam int W = cped_pkg::CNT_W;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [SRC_W-1:0] rsel;
      logic [SRC_W-1:0] fsel;
      logic [SRC_W-1:0] redge;
      logic [SRC_W-1:0] fedge;
      logic [W-1:0] rdb;
      logic [W-1:0] fdb;
      logic [W-1:0] rbk;
      logic [W-1:0] fbk;
      logic [W-1:0] rph;
      logic [W-1:0] fph;
      logic [SRC_W-1:0] rprev;
      logic [SRC_W-1:0] fprev;
      logic rsig_prev;
      logic fsig_prev;
      logic pri;
      logic sec;
      logic sd;
      logic [7:0] div;
      logic p_out;
      logic p_oe_n;
      logic s_out;
      logic s_oe_n;
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cped_state_s;

   cped_state_s s_reg;
   cped_state_s s_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [cped_pkg::N_TMR-1:0] t_start;
   logic [cped_pkg::N_TMR-1:0] t_stop;
   logic [cped_pkg::N_TMR-1:0] t_busy;
   logic [cped_pkg::N_TMR-1:0] t_done;
   logic [cped_pkg::N_TMR-1:0] t_tick;
   logic [W-1:0] t_count [cped_pkg::N_TMR];
   logic tick;
   logic [SRC_W-1:0] r_det;
   logic [SRC_W-1:0] f_det;
   logic rsig;
   logic fsig;
   logic rise_trig;
   logic fall_trig;
   logic rise_go;
   logic fall_go;
   logic have_aw;
   logic have_w;
   logic [ADDR_W-1:0] wa;
   logic [7:0] wd;
   logic [33:0] rd;

   // number of clock cycles covering a chain of delay elements
   function automatic logic [W-1:0] chain_cycles(input logic [W-1:0] n);
      int c;
      c = (int'(n) * cped_pkg::ELEM_NS + cped_pkg::CLK_NS - 1) / cped_pkg::CLK_NS;
      return W'(c);
   endfunction

   // pin enable, override and polarity into {oe_n, level}
   function automatic logic [1:0] pin_drive(input logic pe, input logic sd,
         input logic [1:0] ovr, input logic drv, input logic pol, input logic idle);
      logic [1:0] r;
      r = 2'b10;
      if (!pe) begin
         r = 2'b10;
      end else if (sd) begin
         case (ovr)
            cped_pkg::OVR_LOW: r = 2'b00;
            cped_pkg::OVR_HIGH: r = 2'b01;
            cped_pkg::OVR_TRI: r = 2'b10;
            default: r = {1'b0, idle ^ pol};
         endcase
      end else begin
         r = {1'b0, drv ^ pol};
      end
      return r;
   endfunction

   // register read decode into {valid, data}
   function automatic logic [33:0] reg_read(input logic [ADDR_W-1:0] a,
         input cped_state_s s, input logic [cped_pkg::N_TMR-1:0] b);
      logic [33:0] r;
      r = {1'b0, 33'h000000000};
      if (a == ADDR_W'(cped_pkg::OFF_CTRL_A)) begin
         r = {2'b01, 24'h000000, s.ctrl_a};
      end else if (a == ADDR_W'(cped_pkg::OFF_CTRL_B)) begin
         r = {2'b01, 24'h000000, s.ctrl_b};
      end else if (a == ADDR_W'(cped_pkg::OFF_RSEL)) begin
         r = {2'b01, 32'(s.rsel)};
      end else if (a == ADDR_W'(cped_pkg::OFF_FSEL)) begin
         r = {2'b01, 32'(s.fsel)};
      end else if (a == ADDR_W'(cped_pkg::OFF_REDGE)) begin
         r = {2'b01, 32'(s.redge)};
      end else if (a == ADDR_W'(cped_pkg::OFF_FEDGE)) begin
         r = {2'b01, 32'(s.fedge)};
      end else if (a == ADDR_W'(cped_pkg::OFF_RDB)) begin
         r = {2'b01, 32'(s.rdb)};
      end else if (a == ADDR_W'(cped_pkg::OFF_FDB)) begin
         r = {2'b01, 32'(s.fdb)};
      end else if (a == ADDR_W'(cped_pkg::OFF_RBK)) begin
         r = {2'b01, 32'(s.rbk)};
      end else if (a == ADDR_W'(cped_pkg::OFF_FBK)) begin
         r = {2'b01, 32'(s.fbk)};
      end else if (a == ADDR_W'(cped_pkg::OFF_RPH)) begin
         r = {2'b01, 32'(s.rph)};
      end else if (a == ADDR_W'(cped_pkg::OFF_FPH)) begin
         r = {2'b01, 32'(s.fph)};
      end else if (a == ADDR_W'(cped_pkg::OFF_STAT)) begin
         r = {2'b01, 23'h000000, b, s.sd, s.sec, s.pri};
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // -------------------------------------------------------------
   // timers
   // -------------------------------------------------------------
   cped_tmr_if tmr [cped_pkg::N_TMR] ();

   genvar gi;
   generate
      for (gi = 0; gi < cped_pkg::N_TMR; gi++) begin : g_tmr
         cped_timer u_tmr (
            .clk_i(clk_i),
            .rst_n_i(rst_n),
            .t(tmr[gi])
         );
         assign tmr[gi].start = t_start[gi];
         assign tmr[gi].stop = ~s_reg.ctrl_a[cped_pkg::CA_EN] | t_stop[gi];
         assign tmr[gi].tick = t_tick[gi];
         assign tmr[gi].count = t_count[gi];
         assign t_busy[gi] = tmr[gi].busy;
         assign t_done[gi] = tmr[gi].done;
      end
   endgenerate

   // timing clock as an enable pulse
   always_comb begin
      case (s_reg.ctrl_b[cped_pkg::CB_CSEL +: 2])
         2'b00: tick = 1'b1;
         2'b01: tick = (s_reg.div >= cped_pkg::TICK_DIV_B - 8'h01);
         default: tick = (s_reg.div >= cped_pkg::TICK_DIV_C - 8'h01);
      endcase
   end

   always_comb begin
      t_tick = {cped_pkg::N_TMR{tick}};
      t_count[cped_pkg::T_RPH] = s_reg.rph;
      t_count[cped_pkg::T_FPH] = s_reg.fph;
      t_count[cped_pkg::T_RBK] = s_reg.rbk;
      t_count[cped_pkg::T_FBK] = s_reg.fbk;
      t_count[cped_pkg::T_RDB] = s_reg.rdb;
      t_count[cped_pkg::T_FDB] = s_reg.fdb;
      if (!s_reg.ctrl_b[cped_pkg::CB_RDBM]) begin
         t_tick[cped_pkg::T_RDB] = 1'b1;
         t_count[cped_pkg::T_RDB] = chain_cycles(s_reg.rdb);
      end
      if (!s_reg.ctrl_b[cped_pkg::CB_FDBM]) begin
         t_tick[cped_pkg::T_FDB] = 1'b1;
         t_count[cped_pkg::T_FDB] = chain_cycles(s_reg.fdb);
      end
   end

   // -------------------------------------------------------------
   // event detection and blanking
   // -------------------------------------------------------------
   assign r_det = rise_src_i & (~s_reg.redge | ~s_reg.rprev);
   assign f_det = fall_src_i & (~s_reg.fedge | ~s_reg.fprev);
   assign rsig = |(s_reg.rsel & r_det) & ~t_busy[cped_pkg::T_FBK];
   assign fsig = |(s_reg.fsel & f_det) & ~t_busy[cped_pkg::T_RBK];
   assign rise_trig = rsig & ~s_reg.rsig_prev & s_reg.ctrl_a[cped_pkg::CA_EN];
   assign fall_trig = fsig & ~s_reg.fsig_prev & s_reg.ctrl_a[cped_pkg::CA_EN];
   assign rise_go = (rise_trig & (s_reg.rph == '0)) | t_done[cped_pkg::T_RPH];
   assign fall_go = (fall_trig & (s_reg.fph == '0)) | t_done[cped_pkg::T_FPH];

   // -------------------------------------------------------------
   // bus write capture and read decode
   // -------------------------------------------------------------
   assign have_aw = s_reg.aw_got | s_axi_awvalid_i;
   assign have_w = s_reg.w_got | s_axi_wvalid_i;
   assign wa = s_reg.aw_got ? s_reg.aw_addr : s_axi_awaddr_i;
   assign wd = s_reg.w_got ? s_reg.w_data : s_axi_wdata_i[7:0];
   assign rd = reg_read(s_axi_araddr_i, s_reg, t_busy);

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      logic wr;
      logic lane;
      logic [1:0] pp;
      logic [1:0] sp;
      s_next = s_reg;
      wr = 1'b0;
      pp = 2'b10;
      sp = 2'b10;
      lane = s_reg.w_got ? s_reg.w_lane0 : s_axi_wstrb_i[0];
      t_start = '0;
      t_stop = '0;
      s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
      s_next.rprev = rise_src_i;
      s_next.fprev = fall_src_i;
      s_next.rsig_prev = rsig;
      s_next.fsig_prev = fsig;

      if (!s_reg.ctrl_a[cped_pkg::CA_EN]) begin
         s_next.pri = 1'b0;
         s_next.sec = 1'b1;
      end else begin
         if (rise_trig && s_reg.rph != '0) begin
            t_start[cped_pkg::T_RPH] = 1'b1;
         end
         if (fall_trig && s_reg.fph != '0) begin
            t_start[cped_pkg::T_FPH] = 1'b1;
         end
         if (t_done[cped_pkg::T_RDB]) begin
            s_next.pri = 1'b1;
         end
         if (t_done[cped_pkg::T_FDB]) begin
            s_next.sec = 1'b1;
         end
         if (fall_go) begin
            s_next.pri = 1'b0;
            t_stop[cped_pkg::T_RDB] = 1'b1;
            t_start[cped_pkg::T_FBK] = s_reg.fbk != '0;
            if (s_reg.fdb == '0) begin
               s_next.sec = 1'b1;
            end else begin
               t_start[cped_pkg::T_FDB] = 1'b1;
            end
         end else if (rise_go) begin
            s_next.sec = 1'b0;
            t_stop[cped_pkg::T_FDB] = 1'b1;
            t_start[cped_pkg::T_RBK] = s_reg.rbk != '0;
            if (s_reg.rdb == '0) begin
               s_next.pri = 1'b1;
            end else begin
               t_start[cped_pkg::T_RDB] = 1'b1;
            end
         end
      end

      // shutdown: set wins over the clear
      if (s_reg.ctrl_a[cped_pkg::CA_SDE] || shutdown_i) begin
         s_next.sd = 1'b1;
         s_next.pri = 1'b0;
         s_next.sec = 1'b1;
      end else if (rise_trig) begin
         s_next.sd = 1'b0;
      end

      // pins register the drive levels
      pp = pin_drive(s_reg.ctrl_a[cped_pkg::CA_POE], s_reg.sd, primary_override_i,
                     s_reg.pri, s_reg.ctrl_a[cped_pkg::CA_PPOL], 1'b0);
      sp = pin_drive(s_reg.ctrl_a[cped_pkg::CA_SOE], s_reg.sd, secondary_override_i,
                     s_reg.sec, s_reg.ctrl_a[cped_pkg::CA_SPOL], 1'b1);
      s_next.p_oe_n = pp[1];
      s_next.p_out = pp[0];
      s_next.s_oe_n = sp[1];
      s_next.s_out = sp[0];

      // write channel
      if (s_reg.bvalid && s_axi_bready_i) begin
         s_next.bvalid = 1'b0;
      end
      if (!s_reg.bvalid) begin
         if (have_aw && have_w) begin
            wr = 1'b1;
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = cped_pkg::RESP_OK;
         end else if (s_axi_awvalid_i && !s_reg.aw_got) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr_i;
         end else if (s_axi_wvalid_i && !s_reg.w_got) begin
            s_next.w_got = 1'b1;
            s_next.w_data = s_axi_wdata_i[7:0];
            s_next.w_lane0 = s_axi_wstrb_i[0];
         end
      end
      if (wr) begin
         if (wa == ADDR_W'(cped_pkg::OFF_CTRL_A)) begin
            if (lane) s_next.ctrl_a = {2'b00, wd[5:0]};
         end else if (wa == ADDR_W'(cped_pkg::OFF_CTRL_B)) begin
            if (lane) s_next.ctrl_b = {4'h0, wd[3:0]};
         end else if (wa == ADDR_W'(cped_pkg::OFF_RSEL)) begin
            if (lane) s_next.rsel = wd[SRC_W-1:0];
         end else if (wa == ADDR_W'(cped_pkg::OFF_FSEL)) begin
            if (lane) s_next.fsel = wd[SRC_W-1:0];
         end else if (wa == ADDR_W'(cped_pkg::OFF_REDGE)) begin
            if (lane) s_next.redge = wd[SRC_W-1:0];
         end else if (wa == ADDR_W'(cped_pkg::OFF_FEDGE)) begin
            if (lane) s_next.fedge = wd[SRC_W-1:0];
         end else if (wa == ADDR_W'(cped_pkg::OFF_RDB)) begin
            if (lane) s_next.rdb = wd;
         end else if (wa == ADDR_W'(cped_pkg::OFF_FDB)) begin
            if (lane) s_next.fdb = wd;
         end else if (wa == ADDR_W'(cped_pkg::OFF_RBK)) begin
            if (lane) s_next.rbk = wd;
         end else if (wa == ADDR_W'(cped_pkg::OFF_FBK)) begin
            if (lane) s_next.fbk = wd;
         end else if (wa == ADDR_W'(cped_pkg::OFF_RPH)) begin
            if (lane) s_next.rph = wd;
         end else if (wa == ADDR_W'(cped_pkg::OFF_FPH)) begin
            if (lane) s_next.fph = wd;
         end else if (wa != ADDR_W'(cped_pkg::OFF_STAT)) begin
            s_next.bresp = cped_pkg::RESP_SLVERR;
         end
      end

      // read channel
      if (s_reg.rvalid) begin
         if (s_axi_rready_i) begin
            s_next.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid_i) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd[31:0];
         s_next.rresp = rd[32] ? cped_pkg::RESP_OK : cped_pkg::RESP_SLVERR;
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.ctrl_a <= cped_pkg::CTRL_RST;
         s_reg.ctrl_b <= cped_pkg::CTRL_RST;
         s_reg.rdb <= cped_pkg::CNT_RST;
         s_reg.fdb <= cped_pkg::CNT_RST;
         s_reg.sec <= 1'b1;
         s_reg.p_oe_n <= 1'b1;
         s_reg.s_oe_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready_o = ~s_reg.aw_got & ~s_reg.bvalid;
   assign s_axi_wready_o = ~s_reg.w_got & ~s_reg.bvalid;
   assign s_axi_bvalid_o = s_reg.bvalid;
   assign s_axi_bresp_o = s_reg.bresp;
   assign s_axi_arready_o = ~s_reg.rvalid;
   assign s_axi_rvalid_o = s_reg.rvalid;
   assign s_axi_rdata_o = s_reg.rdata;
   assign s_axi_rresp_o = s_reg.rresp;
   assign primary_output_o = s_reg.p_out;
   assign primary_output_oe_n_o = s_reg.p_oe_n;
   assign secondary_output_o = s_reg.s_out;
   assign secondary_output_oe_n_o = s_reg.s_oe_n;
endmodule

// >>> dv/cped_gate_drv.sv
// gate driver pair seen at the two pins, inputs pulled low when released
`timescale 1ns/10ps
module cped_gate_drv (
   input wire logic hi_i,
   input wire logic hi_oe_n_i,
   input wire logic lo_i,
   input wire logic lo_oe_n_i,
   output logic hi_gate_o,
   output logic lo_gate_o
);
   assign hi_gate_o = hi_oe_n_i ? 1'b0 : hi_i;
   assign lo_gate_o = lo_oe_n_i ? 1'b0 : lo_i;
endmodule

// >>> dv/cped_monitor.sv
// bus handshake and pin override checks on the top ports
`timescale 1ns/10ps
module cped_monitor (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic shutdown_i,
   input wire logic [1:0] primary_override_i,
   input wire logic primary_output_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence wr_both;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence sd_hold(v);
      (shutdown_i && primary_override_i == v)[*4];
   endsequence
   a_write_resp_next: assert property (wr_both |=> s_axi_bvalid_o) else $error("no bvalid");
   a_read_resp_next: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("no rvalid");
   a_bvalid_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("bvalid dropped");
   a_rvalid_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
      else $error("rvalid dropped");
   a_read_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("arready");
   a_bvalid_cause: assert property ($rose(s_axi_bvalid_o) |-> $past(s_axi_wvalid_i || !s_axi_wready_o))
      else $error("bvalid uncaused");
   a_pins_released: assert property ($rose(resetn_i) |-> primary_output_oe_n_o[*2])
      else $error("pin driven after reset");
   a_ovr_tristate: assert property (sd_hold(2'h2) |-> primary_output_oe_n_o)
      else $error("pin driven in tristate override");
endmodule
bind cped_top cped_monitor i_cped_monitor (.*);

// >>> dv/tb_top.sv
// self-checking bench for the complementary pwm stage
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
   logic [3:0] s_axi_wstrb_i = 4'hF, rise_src_i = 4'h0, fall_src_i = 4'h0;
   logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, shutdown_i = 0;
   logic [1:0] primary_override_i = 2'h0, secondary_override_i = 2'h0;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic primary_output_o, primary_output_oe_n_o, secondary_output_o, secondary_output_oe_n_o;
   logic pg, sg;
   logic [2:0] h;
   logic [16:0] rows [9] = '{{8'h0C,4'h0,1'b0,4'h1}, {8'h3C,4'h0,1'b0,4'h2},
      {8'h0D,4'h2,1'b0,4'h1}, {8'h0D,4'h6,1'b0,4'h2}, {8'h0D,4'h0,1'b1,4'h1},
      {8'h3D,4'h4,1'b0,4'h1}, {8'h0D,4'h0,1'b1,4'h1}, {8'h05,4'h0,1'b1,4'h4},
      {8'h0D,4'h0,1'b0,4'h1}};
   int n_fail = 0, n_checks = 0, cyc = 0, n;
   cped_top i_cped_top (.*);
   cped_gate_drv i_cped_gate_drv (.hi_i(primary_output_o), .hi_oe_n_i(primary_output_oe_n_o),
      .lo_i(secondary_output_o), .lo_oe_n_i(secondary_output_oe_n_o), .hi_gate_o(pg),
      .lo_gate_o(sg));
   initial forever #5 clk_i = ~clk_i;
   task stop_test;
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h0, v};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(negedge clk_i);
         h = {s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o};
         r = s_axi_bresp_o;
         @(posedge clk_i);
         if (h[2]) s_axi_awvalid_i <= 1'b0;
         if (h[1]) s_axi_wvalid_i <= 1'b0;
      end while (!h[0]);
      s_axi_bready_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(negedge clk_i);
         h = {1'b0, s_axi_arready_o, s_axi_rvalid_o};
         d = s_axi_rdata_o;
         r = s_axi_rresp_o;
         @(posedge clk_i);
         if (h[1]) s_axi_arvalid_i <= 1'b0;
      end while (!h[0]);
      s_axi_rready_i <= 1'b0;
   endtask
   // pin check: {primary oe_n, secondary oe_n, primary gate, secondary gate}
   task pins(input logic [3:0] e);
      @(negedge clk_i);
      chk("pins", e, {primary_output_oe_n_o, secondary_output_oe_n_o, pg, sg});
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test;
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(cped_pkg::OFF_STAT);
      chk("status", 32'h2, d);
      pins(4'hC);
      wr(cped_pkg::OFF_RSEL, 8'h04);
      wr(cped_pkg::OFF_FSEL, 8'h01);
      wr(cped_pkg::OFF_CTRL_B, 8'h03);
      foreach (rows[i]) begin
         wr(cped_pkg::OFF_CTRL_A, rows[i][16:9]);
         rise_src_i <= rows[i][8:5];
         fall_src_i <= {3'h0, rows[i][4]};
         repeat (4) @(posedge clk_i);
         pins(rows[i][3:0]);
      end
      wr(cped_pkg::OFF_RDB, 8'h04);
      rise_src_i <= 4'h4;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
         if (n == 3) chk("sec off", 0, sg);
      end while (pg !== 1'b1 && n < 40);
      chk("dead band", 7, n);
      wr(cped_pkg::OFF_RDB, 8'h08);
      rise_src_i <= 4'h0;
      fall_src_i <= 4'h1;
      repeat (4) @(posedge clk_i);
      fall_src_i <= 4'h0;
      rise_src_i <= 4'h4;
      repeat (3) @(posedge clk_i);
      fall_src_i <= 4'h1;
      h = 3'h0;
      repeat (14) @(negedge clk_i) h[0] = h[0] | pg;
      chk("overlap", 0, h[0]);
      pins(4'h1);
      wr(cped_pkg::OFF_RDB, 8'h00);
      wr(cped_pkg::OFF_RBK, 8'h06);
      rise_src_i <= 4'h0;
      fall_src_i <= 4'h0;
      @(posedge clk_i);
      rise_src_i <= 4'h4;
      repeat (2) @(posedge clk_i);
      fall_src_i <= 4'h1;
      @(posedge clk_i);
      fall_src_i <= 4'h0;
      repeat (6) @(posedge clk_i);
      pins(4'h2);
      primary_override_i <= 2'h2;
      secondary_override_i <= 2'h1;
      shutdown_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      pins(4'h9);
      primary_override_i <= 2'h1;
      repeat (5) @(posedge clk_i);
      shutdown_i <= 1'b0;
      wr(cped_pkg::OFF_CTRL_A, 8'h3E);
      pins(4'h3);
      rd(cped_pkg::OFF_STAT);
      chk("shutdown on", 1, d[2]);
      wr(cped_pkg::OFF_CTRL_A, 8'h0D);
      rise_src_i <= 4'h0;
      repeat (3) @(posedge clk_i);
      pins(4'h3);
      rise_src_i <= 4'h4;
      repeat (4) @(posedge clk_i);
      rd(cped_pkg::OFF_STAT);
      chk("shutdown off", 0, d[2]);
      wr(8'h40, 8'h01);
      chk("bresp", cped_pkg::RESP_SLVERR, r);
      rd(8'h40);
      chk("rresp", cped_pkg::RESP_SLVERR, r);
      wr(cped_pkg::OFF_FEDGE, 8'h01);
      wr(cped_pkg::OFF_FPH, 8'h03);
      wr(cped_pkg::OFF_FDB, 8'h04);
      wr(cped_pkg::OFF_CTRL_B, 8'h01);
      fall_src_i <= 4'h1;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
         if (n == 5) chk("phase", 1, pg);
      end while (sg !== 1'b1 && n < 40);
      chk("chain dead band", 8, n);
      @(posedge clk_i);
      rise_src_i <= 4'h0;
      fall_src_i <= 4'h0;
      @(posedge clk_i);
      rise_src_i <= 4'h4;
      @(posedge clk_i);
      fall_src_i <= 4'h1;
      repeat (12) @(posedge clk_i);
      pins(4'h2);
      wr(cped_pkg::OFF_CTRL_B, 8'h03);
      wr(cped_pkg::OFF_FDB, 8'h08);
      fall_src_i <= 4'h0;
      rise_src_i <= 4'h0;
      @(posedge clk_i);
      fall_src_i <= 4'h1;
      repeat (6) @(posedge clk_i);
      rise_src_i <= 4'h4;
      h = 3'h0;
      repeat (14) @(negedge clk_i) h[0] = h[0] | sg;
      chk("overlap rise", 0, h[0]);
      pins(4'h2);
      stop_test;
   end
endmodule
